// file: verilog/timer_pkg.sv
// Shared constants and types of the dual timer/counter block
package timer_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL = 10'h088;
    localparam logic [9:0] IDX_MODE = 10'h089;
    localparam logic [9:0] IDX_LOW0 = 10'h08A;
    localparam logic [9:0] IDX_LOW1 = 10'h08B;
    localparam logic [9:0] IDX_HIGH0 = 10'h08C;
    localparam logic [9:0] IDX_HIGH1 = 10'h08D;
    localparam logic [9:0] IDX_RATE = 10'h08E;
    localparam logic [9:0] IDX_PINCFG = 10'h096;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h0A0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0A1;

    // Field positions
    localparam int RATE_BIT0 = 3;
    localparam int RATE_BIT1 = 4;
    localparam int TOGGLE_EN_BIT0 = 2;
    localparam int TOGGLE_EN_BIT1 = 3;
    localparam int RUN_BIT0 = 4;
    localparam int FLAG_BIT0 = 5;
    localparam int RUN_BIT1 = 6;
    localparam int FLAG_BIT1 = 7;
    localparam int MODE_NIBBLE = 4;
    localparam int CT_OFS = 2;
    localparam int GATE_OFS = 3;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic PIN_LATCH_RESET = 1'h1;

    // Machine cycle timing in system clocks
    localparam logic [3:0] LAST_PHASE = 4'hB;
    localparam logic [3:0] UPDATE_PHASE = 4'h3;
    localparam logic [3:0] SAMPLE_PHASE = 4'h4;
    localparam logic [1:0] TURBO_PHASE = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_PRESCALE = 2'b00,
        MODE_FULL = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } mode_t;
endpackage : timer_pkg

// file: verilog/count_sampler.sv
// Pin synchroniser with once-per-machine-cycle sampling and falling edge latch
module count_sampler (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic pin_async,
    input wire logic sample_en,
    input wire logic consume,
    output logic pin_level,
    output logic fall_pending
);
    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;
    logic pend_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 1'h1;
            sync2_reg <= 1'h1;
        end else begin
            sync1_reg <= pin_async;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            last_reg <= 1'h1;
        end else if (sample_en) begin
            last_reg <= sync2_reg;
        end
    end

    // Sample and consume fall in different phases, so they never collide
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= 1'h0;
        end else if (sample_en && last_reg && !sync2_reg) begin
            pend_reg <= 1'h1;
        end else if (consume) begin
            pend_reg <= 1'h0;
        end
    end

    assign pin_level = sync2_reg;
    assign fall_pending = pend_reg;
endmodule : count_sampler

// file: verilog/dual_timer.sv
// Two 16-bit timer/counters with overflow toggle pins behind an AXI4-Lite slave
module dual_timer
    import timer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic count_pin_zero_in,
    output logic count_pin_zero_out,
    output logic count_pin_zero_oe_b,
    input wire logic count_pin_one_in,
    output logic count_pin_one_out,
    output logic count_pin_one_oe_b,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic isr_enter_zero,
    input wire logic isr_enter_one,
    output logic irq
);
    localparam int NUM_TIMERS = 2;

    logic [3:0] phase_reg;
    logic upd_phase;
    logic smp_phase;
    logic turbo_phase;

    logic [7:0] timer_mode_register;
    logic [7:0] timer_clock_rate_select;
    logic [1:0] run_reg;
    logic [1:0] flag_reg;
    logic [1:0] toggle_en_reg;
    logic [1:0] toggle_reg;
    logic [1:0] stat_reg;
    logic [1:0] mask_reg;
    logic [7:0] low_byte_reg [0:1];
    logic [7:0] high_byte_reg [0:1];
    logic [7:0] low_byte_next [0:1];
    logic [7:0] high_byte_next [0:1];

    logic [1:0] pin_async;
    logic [1:0] gate_async;
    logic [1:0] gate_level;
    logic [1:0] fall_pend;
    logic [1:0] isr_enter;
    logic [1:0] rate;
    logic [1:0] ct_sel;
    logic [1:0] gate_sel;
    mode_t mode_w [0:1];
    logic [1:0] tick;
    logic [1:0] inc;
    logic [1:0] ovf_main;
    logic [1:0] ovf_evt;
    logic split_mode;
    logic high_split_tick;
    logic high_split_ovf;

    logic aw_hold_reg;
    logic w_hold_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic wr_fire;
    logic wr_en;
    logic [9:0] wr_idx;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic rd_hit;

    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx == IDX_CTRL) || (idx == IDX_MODE) || (idx == IDX_LOW0) || (idx == IDX_LOW1) ||
                     (idx == IDX_HIGH0) || (idx == IDX_HIGH1) || (idx == IDX_RATE) ||
                     (idx == IDX_PINCFG) || (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK);
    endfunction : idx_mapped

    // Machine cycle of twelve system clocks
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= 4'h0;
        end else if (phase_reg == LAST_PHASE) begin
            phase_reg <= 4'h0;
        end else begin
            phase_reg <= phase_reg + 4'h1;
        end
    end

    assign upd_phase = (phase_reg == UPDATE_PHASE);
    assign smp_phase = (phase_reg == SAMPLE_PHASE);
    assign turbo_phase = (phase_reg[1:0] == TURBO_PHASE);

    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_idx = aw_addr_reg[11:2];
    assign wr_byte = w_data_reg[7:0];
    assign wr_en = wr_fire && w_strb_reg[0] && (aw_addr_reg[1:0] == 2'h0) && idx_mapped(wr_idx);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_hold_reg <= 1'h0;
            aw_addr_reg <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'h1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_reg <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            w_hold_reg <= 1'h0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'h1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_reg <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bvalid_reg <= 1'h0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'h1;
            bresp_reg <= (idx_mapped(wr_idx) && aw_addr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'h0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Configuration registers
    // Mode register storage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer_mode_register <= RESET_BYTE;
        end else if (wr_en && wr_idx == IDX_MODE) begin
            timer_mode_register <= wr_byte;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer_clock_rate_select <= RESET_BYTE;
        end else if (wr_en && wr_idx == IDX_RATE) begin
            timer_clock_rate_select <= RESET_BYTE;
            timer_clock_rate_select[RATE_BIT0] <= wr_byte[RATE_BIT0];
            timer_clock_rate_select[RATE_BIT1] <= wr_byte[RATE_BIT1];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            run_reg <= 2'h0;
            toggle_en_reg <= 2'h0;
            mask_reg <= 2'h0;
        end else if (wr_en) begin
            if (wr_idx == IDX_CTRL) begin
                run_reg <= {wr_byte[RUN_BIT1], wr_byte[RUN_BIT0]};
            end
            if (wr_idx == IDX_PINCFG) begin
                toggle_en_reg <= {wr_byte[TOGGLE_EN_BIT1], wr_byte[TOGGLE_EN_BIT0]};
            end
            if (wr_idx == IDX_IRQ_MASK) begin
                mask_reg <= wr_byte[1:0];
            end
        end
    end

    assign isr_enter = {isr_enter_one, isr_enter_zero};
    assign pin_async = {count_pin_one_in, count_pin_zero_in};
    assign gate_async = {ext_irq_pin_one, ext_irq_pin_zero};
    assign split_mode = (mode_w[0] == MODE_SPLIT);
    assign high_split_tick = (rate[0] ? turbo_phase : upd_phase) && run_reg[1];
    assign high_split_ovf = split_mode && high_split_tick && (high_byte_reg[0] == 8'hFF);

    // Timer 0 in split mode lends timer 1's flag and toggle to its high byte
    assign ovf_evt[0] = ovf_main[0];
    assign ovf_evt[1] = split_mode ? high_split_ovf : ovf_main[1];

    genvar i;
    generate
        for (i = 0; i < NUM_TIMERS; i++) begin : gen_timer
            count_sampler u_count (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .pin_async(pin_async[i]),
                .sample_en(smp_phase),
                .consume(upd_phase),
                .pin_level(),
                .fall_pending(fall_pend[i])
            );

            count_sampler u_gate (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .pin_async(gate_async[i]),
                .sample_en(smp_phase),
                .consume(upd_phase),
                .pin_level(gate_level[i]),
                .fall_pending()
            );

            assign mode_w[i] = mode_t'(timer_mode_register[MODE_NIBBLE * i +: 2]);
            assign ct_sel[i] = timer_mode_register[MODE_NIBBLE * i + CT_OFS];
            assign gate_sel[i] = timer_mode_register[MODE_NIBBLE * i + GATE_OFS];
            assign rate[i] = timer_clock_rate_select[RATE_BIT0 + i];

            // Count source, updated at update phase, or every fourth clock (phases 3, 7 and 11) when the timer's rate bit is set and ct_sel is clear
            assign tick[i] = ct_sel[i] ? (upd_phase && fall_pend[i]) : (rate[i] ? turbo_phase : upd_phase);
            // Gate and run qualify every tick; the split-mode high byte of timer 0 is qualified only by timer 1's run bit
            assign inc[i] = tick[i] && run_reg[i] && (!gate_sel[i] || gate_level[i]);

            always_comb begin
                low_byte_next[i] = low_byte_reg[i];
                high_byte_next[i] = high_byte_reg[i];
                ovf_main[i] = 1'h0;
                if (inc[i]) begin
                    unique case (mode_w[i])
                        MODE_PRESCALE: begin
                            low_byte_next[i][4:0] = low_byte_reg[i][4:0] + 5'h01;
                            if (low_byte_reg[i][4:0] == 5'h1F) begin
                                high_byte_next[i] = high_byte_reg[i] + 8'h01;
                                ovf_main[i] = (high_byte_reg[i] == 8'hFF);
                            end
                        end
                        MODE_FULL: begin
                            {high_byte_next[i], low_byte_next[i]} = {high_byte_reg[i], low_byte_reg[i]} + 16'h0001;
                            ovf_main[i] = ({high_byte_reg[i], low_byte_reg[i]} == 16'hFFFF);
                        end
                        MODE_RELOAD: begin
                            if (low_byte_reg[i] == 8'hFF) begin
                                low_byte_next[i] = high_byte_reg[i];
                                ovf_main[i] = 1'h1;
                            end else begin
                                low_byte_next[i] = low_byte_reg[i] + 8'h01;
                            end
                        end
                        MODE_SPLIT: begin
                            // Timer 1 simply halts in this mode
                            if (i == 0) begin
                                low_byte_next[i] = low_byte_reg[i] + 8'h01;
                                ovf_main[i] = (low_byte_reg[i] == 8'hFF);
                            end
                        end
                    endcase
                end
                if (i == 0 && split_mode && high_split_tick) begin
                    high_byte_next[i] = high_byte_reg[i] + 8'h01;
                end
            end

            // Byte registers; a software write beats a same-cycle increment
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    low_byte_reg[i] <= RESET_BYTE;
                end else if (wr_en && wr_idx == (i == 0 ? IDX_LOW0 : IDX_LOW1)) begin
                    low_byte_reg[i] <= wr_byte;
                end else begin
                    low_byte_reg[i] <= low_byte_next[i];
                end
            end

            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    high_byte_reg[i] <= RESET_BYTE;
                end else if (wr_en && wr_idx == (i == 0 ? IDX_HIGH0 : IDX_HIGH1)) begin
                    high_byte_reg[i] <= wr_byte;
                end else begin
                    high_byte_reg[i] <= high_byte_next[i];
                end
            end

            // Overflow set wins over service entry and software clear
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    flag_reg[i] <= 1'h0;
                end else if (ovf_evt[i]) begin
                    flag_reg[i] <= 1'h1;
                end else if (wr_en && wr_idx == IDX_CTRL) begin
                    flag_reg[i] <= wr_byte[i == 0 ? FLAG_BIT0 : FLAG_BIT1];
                end else if (isr_enter[i]) begin
                    flag_reg[i] <= 1'h0;
                end
            end

            // Pin latch inverts on each overflow while toggling is enabled
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    toggle_reg[i] <= PIN_LATCH_RESET;
                end else if (ovf_evt[i] && toggle_en_reg[i]) begin
                    toggle_reg[i] <= !toggle_reg[i];
                end
            end

            // Sticky status, write one to clear; a new event wins
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    stat_reg[i] <= 1'h0;
                end else if (ovf_evt[i]) begin
                    stat_reg[i] <= 1'h1;
                end else if (wr_en && wr_idx == IDX_IRQ_STAT && wr_byte[i]) begin
                    stat_reg[i] <= 1'h0;
                end
            end
        end
    endgenerate

    assign count_pin_zero_out = toggle_reg[0];
    assign count_pin_one_out = toggle_reg[1];
    // Released pin floats high so it still works as a count input
    assign count_pin_zero_oe_b = !toggle_en_reg[0];
    assign count_pin_one_oe_b = !toggle_en_reg[1];
    assign irq = |(stat_reg & mask_reg);

    // AXI4-Lite read path, one cycle to answer
    always_comb begin
        rd_byte = RESET_BYTE;
        rd_hit = 1'h1;
        unique case (s_axi_araddr[11:2])
            IDX_CTRL: rd_byte = {flag_reg[1], run_reg[1], flag_reg[0], run_reg[0], 4'h0};
            IDX_MODE: rd_byte = timer_mode_register;
            IDX_LOW0: rd_byte = low_byte_reg[0];
            IDX_LOW1: rd_byte = low_byte_reg[1];
            IDX_HIGH0: rd_byte = high_byte_reg[0];
            IDX_HIGH1: rd_byte = high_byte_reg[1];
            IDX_RATE: rd_byte = timer_clock_rate_select;
            IDX_PINCFG: rd_byte = {4'h0, toggle_en_reg, 2'h0};
            IDX_IRQ_STAT: rd_byte = {6'h00, stat_reg};
            IDX_IRQ_MASK: rd_byte = {6'h00, mask_reg};
            default: rd_hit = 1'h0;
        endcase
        if (s_axi_araddr[1:0] != 2'h0) begin
            rd_hit = 1'h0;
        end
    end

    assign s_axi_arready = !rvalid_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_reg <= 1'h0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'h1;
            rdata_reg <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'h0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Checks
    a_phase_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        phase_reg == LAST_PHASE |=> phase_reg == 4'h0 ##3 upd_phase ##1 smp_phase)
        else $error("machine cycle phase sequence broken");

    a_flag_on_ovf: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovf_evt[0] |=> flag_reg[0] && stat_reg[0])
        else $error("overflow did not set flag and status");

    a_toggle_flip: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovf_evt[1] && toggle_en_reg[1] |=> count_pin_one_out != $past(count_pin_one_out) && !count_pin_one_oe_b)
        else $error("toggle pin did not invert on overflow");

    a_halt_keeps: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !run_reg[0] && !(wr_en && wr_idx == IDX_LOW0) |=> low_byte_reg[0] == $past(low_byte_reg[0]))
        else $error("halted timer changed its count");

    a_rate_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
        inc[0] && !ct_sel[0] |-> (rate[0] ? phase_reg[1:0] == 2'h3 : phase_reg == UPDATE_PHASE))
        else $error("timer tick at wrong phase for its rate");

    a_edge_later: assert property (@(posedge clk_sys) disable iff (!rst_b)
        inc[1] && ct_sel[1] |-> upd_phase && $past(fall_pend[1], 1))
        else $error("counter increment without a pending edge");

    a_full_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovf_main[0] && mode_w[0] == MODE_FULL && !wr_en |=> low_byte_reg[0] == 8'h00 && high_byte_reg[0] == 8'h00)
        else $error("16-bit overflow did not wrap to zero");

    a_reload_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovf_main[1] && mode_w[1] == MODE_RELOAD && !wr_en |=> low_byte_reg[1] == high_byte_reg[1])
        else $error("auto-reload did not copy high byte");

    a_gate_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
        gate_sel[0] && !gate_level[0] |-> !inc[0])
        else $error("gated timer counted with gate pin low");

    a_bresp_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
endmodule : dual_timer

// file: testbench/pulse_source.sv
// Event source that drives a count pin with clean pulses
module pulse_source (
    input wire logic clk_sys,
    input wire logic [3:0] n_pulses,
    input wire logic go,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = 1'h1;
    always @(posedge go) begin
        repeat (n_pulses) begin
            repeat (24) @(posedge clk_sys);
            pin <= 1'h0;
            repeat (24) @(posedge clk_sys);
            pin <= 1'h1;
        end
    end
endmodule : pulse_source

// file: testbench/dual_timer_test.sv
// Self-checking bench of the dual timer block
module dual_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import timer_pkg::*;
    logic clk_sys = 1'h0, rst_b = 1'h0, go = 1'h0, gate0 = 1'h1, isr0 = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, out0, oe0_b, out1, oe1_b, src0, src1;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata;
    logic [7:0] rd, held;
    int err_total = 0, checks_done = 0, cyc = 0;
    // Pin level: the block drives while its enable is low
    wire pin0 = oe0_b ? src0 : out0;
    wire pin1 = oe1_b ? src1 : out1;
    always #5 clk_sys = ~clk_sys;
    dual_timer dual_timer_i (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_pin_zero_in(pin0),
        .count_pin_zero_out(out0), .count_pin_zero_oe_b(oe0_b), .count_pin_one_in(pin1),
        .count_pin_one_out(out1), .count_pin_one_oe_b(oe1_b), .ext_irq_pin_zero(gate0),
        .ext_irq_pin_one(1'h1), .isr_enter_zero(isr0), .isr_enter_one(1'h0), .irq(irq));
    pulse_source pulse_source_i (.clk_sys(clk_sys), .n_pulses(4'h3), .go(go), .pin(src0));
    pulse_source pulse_source_i1 (.clk_sys(clk_sys), .n_pulses(4'h3), .go(go), .pin(src1));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'h1) begin
            err_total++;
            $display("[FAIL] %0t count %h outside %h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    // Handshakes are judged at the falling edge, so they hold at the next rising edge
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic a, w, b;
        @(posedge clk_sys);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(negedge clk_sys);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            rsp = bresp;
            @(posedge clk_sys);
            if (a) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
        end while (!b);
        bready <= 1'h0;
    endtask : wr
    task automatic rdr(input logic [9:0] idx);
        logic a, r;
        @(posedge clk_sys);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(negedge clk_sys);
            a = arvalid && arready;
            r = rvalid;
            rd = rdata[7:0];
            rsp = rresp;
            @(posedge clk_sys);
            if (a) arvalid <= 1'h0;
        end while (!r);
        rready <= 1'h0;
    endtask : rdr
    task automatic t_reset();
        rdr(IDX_RATE);
        chk(rd, RESET_BYTE);
        rdr(10'h3FF);
        chk({6'h0, rsp}, {6'h0, RESP_SLVERR});
        wr(10'h3FF, 8'h00);
        chk({6'h0, rsp}, {6'h0, RESP_SLVERR});
    endtask : t_reset
    // Gated timer, gate pin high: count tracks the chosen rate, then halts
    task automatic t_rate();
        for (int r = 0; r < 2; r++) begin
            wr(IDX_MODE, 8'h09);
            wr(IDX_LOW0, 8'h00);
            wr(IDX_RATE, r ? 8'h08 : 8'h00);
            wr(IDX_CTRL, 8'h10);
            repeat (120) @(posedge clk_sys);
            wr(IDX_CTRL, 8'h00);
            rdr(IDX_LOW0);
            chk_rng(rd, r ? 8'h1D : 8'h09, r ? 8'h20 : 8'h0B);
            held = rd;
            repeat (60) @(posedge clk_sys);
            rdr(IDX_LOW0);
            chk(rd, held);
        end
    endtask : t_rate
    task automatic t_gate();
        gate0 <= 1'h0;
        wr(IDX_LOW0, 8'h00);
        wr(IDX_CTRL, 8'h10);
        repeat (60) @(posedge clk_sys);
        rdr(IDX_LOW0);
        chk(rd, 8'h00);
        gate0 <= 1'h1;
        wr(IDX_CTRL, 8'h00);
    endtask : t_gate
    task automatic t_count();
        for (int i = 0; i < 2; i++) begin
            wr(IDX_MODE, i ? 8'h50 : 8'h05);
            wr(i ? IDX_LOW1 : IDX_LOW0, 8'h00);
            wr(IDX_CTRL, i ? 8'h40 : 8'h10);
            go <= 1'h1;
            @(posedge clk_sys);
            go <= 1'h0;
            repeat (180) @(posedge clk_sys);
            wr(IDX_CTRL, 8'h00);
            rdr(i ? IDX_LOW1 : IDX_LOW0);
            chk(rd, 8'h03);
        end
    endtask : t_count
    task automatic t_ovf();
        wr(IDX_PINCFG, 8'h04);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_MODE, 8'h01);
        wr(IDX_HIGH0, 8'hFF);
        wr(IDX_LOW0, 8'hFE);
        @(negedge clk_sys);
        chk({6'h0, oe0_b, out0}, 8'h01);
        wr(IDX_CTRL, 8'h10);
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({6'h0, irq, out0}, 8'h02);
        rdr(IDX_CTRL);
        chk(rd, 8'h30);
        isr0 <= 1'h1;
        @(posedge clk_sys);
        isr0 <= 1'h0;
        rdr(IDX_CTRL);
        chk(rd, 8'h10);
        wr(IDX_IRQ_STAT, 8'h01);
        @(negedge clk_sys);
        chk({7'h0, irq}, 8'h00);
    endtask : t_ovf
    // Timer 0 prescaled 8-bit, timer 1 auto-reload, both at divide-by-4, toggle on timer 1
    task automatic t_modes();
        wr(IDX_CTRL, 8'h00);
        wr(IDX_PINCFG, 8'h08);
        wr(IDX_RATE, 8'h18);
        wr(IDX_MODE, 8'h20);
        wr(IDX_HIGH0, 8'hFF);
        wr(IDX_LOW0, 8'h1E);
        wr(IDX_HIGH1, 8'hF0);
        wr(IDX_LOW1, 8'hFE);
        wr(IDX_CTRL, 8'h50);
        repeat (40) @(posedge clk_sys);
        rdr(IDX_CTRL);
        chk(rd, 8'hF0);
        @(negedge clk_sys);
        chk({6'h0, oe1_b, out1}, 8'h00);
        wr(IDX_CTRL, 8'h00);
        rdr(IDX_LOW1);
        chk_rng(rd, 8'hF0, 8'hFF);
        rdr(IDX_HIGH0);
        chk(rd, 8'h00);
        rdr(IDX_IRQ_STAT);
        chk(rd, 8'h03);
    endtask : t_modes
    task automatic complete_run();
        $display("checks_done %0d err_total %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // Hang guard, well above the roughly one thousand cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'h1;
        t_reset();
        t_rate();
        t_gate();
        t_count();
        t_ovf();
        t_modes();
        complete_run();
    end
endmodule : dual_timer_test
